/* pkg/wws_edge_if.sv */
// Carrier for the synchronised service input and its falling-edge pulse
interface wws_edge_if;
  logic sampled;
  logic fallPulse;

  modport producer (
    output sampled,
    output fallPulse
  );

  modport consumer (
    input sampled,
    input fallPulse
  );
endinterface : wws_edge_if

/* pkg/wws_pkg.sv */
// Shared constants and types for the wake-up watchdog reset supervisor
package wws_pkg;

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
  // Nominal wake-up period in microseconds
  localparam int unsigned WAKE_PERIOD_US = 25_000;
  localparam int unsigned WAKE_PERIOD_CYC = WAKE_PERIOD_US * CLK_PER_US;
  // Reset delay is one eighth of the period, start delay one half
  localparam int unsigned RST_DELAY_DIV = 8;
  localparam int unsigned START_DELAY_DIV = 2;
  // Least gap the host leaves from wake-up rise to its service edge
  localparam int unsigned SERVICE_GAP_NS = 5_000;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic RESET_N_RST = 1'h0;
  localparam logic WAKE_RST = 1'h0;
  localparam logic REG_ON_RST = 1'h0;
  localparam logic SYNC_RST = 1'h1;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_PWRUP = 3'h1,
    ST_RSTDLY = 3'h3,
    ST_RUN = 3'h2,
    ST_WDRST = 3'h6
  } wws_state_t;

endpackage : wws_pkg

/* rtl/wws_edge_detect.sv */
// Synchroniser and falling-edge detector for the host service input
module wws_edge_detect (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_service_pulse_in,
  wws_edge_if.producer edge_o
);
  import wws_pkg::*;

  logic syncA_reg;
  logic syncB_reg;
  logic prev_reg;
  logic fall_reg;

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      syncA_reg <= SYNC_RST;
      syncB_reg <= SYNC_RST;
    end else begin
      syncA_reg <= host_service_pulse_in;
      syncB_reg <= syncA_reg;
    end
  end

  // ----------------------------------------------------------------
  // Falling edge from consecutive samples
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_reg <= SYNC_RST;
      fall_reg <= 1'h0;
    end else begin
      prev_reg <= syncB_reg;
      fall_reg <= prev_reg & ~syncB_reg;
    end
  end

  assign edge_o.sampled = prev_reg;
  assign edge_o.fallPulse = fall_reg;

endmodule : wws_edge_detect

/* rtl/wws_supervisor.sv */
// Wake-up generator, watchdog and reset supervisor
//
// What this block does
// - Wake-up output is a square wave, 50% duty, period from one parameter.
// - Only falling service edges count; at least one needed each wake-up period.
// - First accepted edge in a period forces wake-up low for the rest of it.
// - Further service pulses in the same period are ignored.
// - A period with no service edge ends in a reset pulse.
// - At power-up reset stays asserted until the output is in regulation.
// - Undervoltage asserts reset until it clears plus a full reset delay.
// - Supply-input-low asserts reset whatever the output voltage shows.
// - Wake-up output stays low while reset is asserted.
// - After reset releases, wait the start delay, then begin a fresh wake-up cycle.
// - Period, reset delay and start delay all derive from one setting.
// - Regulator is on while enable is high, shut down while low.
module wws_supervisor #(
  parameter int unsigned PERIOD_CYC = wws_pkg::WAKE_PERIOD_CYC,
  parameter int unsigned CNT_W = 32
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_service_pulse_in,
  input wire logic regulated_output_in_reg,
  input wire logic regulated_output_low,
  input wire logic supply_input_low,
  input wire logic enableIn,
  output logic wakeupOut,
  output logic resetOutN,
  output logic regulatorOn
);
  import wws_pkg::*;

  // ----------------------------------------------------------------
  // Interval ends, all from the single period setting
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] PER_LAST = CNT_W'(PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(PERIOD_CYC / START_DELAY_DIV);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(PERIOD_CYC / START_DELAY_DIV - 1);
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(PERIOD_CYC / RST_DELAY_DIV - 1);

  wws_edge_if edgeBus ();

  wws_state_t state_reg;
  wws_state_t state_next;
  logic [CNT_W-1:0] tick_reg;
  logic preDelay_reg;
  logic serviced_reg;
  logic wakeupOut_reg;
  logic resetOutN_reg;
  logic regulatorOn_reg;
  logic powerGood;
  logic inCycle;
  logic periodEnd;
  logic acceptEdge;
  logic stateChange;

  wws_edge_detect u_edge (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .host_service_pulse_in(host_service_pulse_in),
    .edge_o(edgeBus)
  );

  // ----------------------------------------------------------------
  // Cycle conditions
  // ----------------------------------------------------------------
  assign powerGood = regulated_output_in_reg & ~regulated_output_low & ~supply_input_low;
  assign inCycle = (state_reg == ST_RUN) && !preDelay_reg;
  assign periodEnd = inCycle && (tick_reg == PER_LAST);
  assign acceptEdge = inCycle && edgeBus.fallPulse && !serviced_reg;
  assign stateChange = (state_next != state_reg);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (!enableIn) begin
      state_next = ST_OFF;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_next = ST_PWRUP;
        end
        ST_PWRUP: begin
          if (powerGood) begin
            state_next = ST_RSTDLY;
          end
        end
        ST_RSTDLY: begin
          if (!powerGood) begin
            state_next = ST_PWRUP;
          end else if (tick_reg == RD_LAST) begin
            state_next = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!powerGood) begin
            state_next = ST_PWRUP;
          end else if (periodEnd && !serviced_reg && !edgeBus.fallPulse) begin
            state_next = ST_WDRST;
          end
        end
        ST_WDRST: begin
          if (!powerGood) begin
            state_next = ST_PWRUP;
          end else if (tick_reg == RD_LAST) begin
            state_next = ST_RUN;
          end
        end
        default: begin
          state_next = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Single tick counter shared by every interval
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_reg <= '0;
    end else if (stateChange) begin
      tick_reg <= '0;
    end else if (state_reg == ST_RUN) begin
      if ((preDelay_reg && tick_reg == HALF_LAST) || periodEnd) begin
        tick_reg <= '0;
      end else begin
        tick_reg <= tick_reg + CNT_W'(1);
      end
    end else if (state_reg == ST_RSTDLY || state_reg == ST_WDRST) begin
      tick_reg <= tick_reg + CNT_W'(1);
    end else begin
      tick_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Start delay after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      preDelay_reg <= 1'h1;
    end else if (state_next != ST_RUN) begin
      preDelay_reg <= 1'h1;
    end else if (preDelay_reg && tick_reg == HALF_LAST) begin
      preDelay_reg <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Service flag for the current wake-up period
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      serviced_reg <= 1'h0;
    end else if (state_next != ST_RUN || periodEnd || preDelay_reg) begin
      serviced_reg <= 1'h0;
    end else if (acceptEdge) begin
      serviced_reg <= 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wakeupOut_reg <= WAKE_RST;
    end else begin
      // High in the first half of a period, cut short by service, low in reset
      wakeupOut_reg <= inCycle && (state_next == ST_RUN) && !periodEnd && (tick_reg < HALF_CYC)
                       && !serviced_reg && !acceptEdge;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resetOutN_reg <= RESET_N_RST;
    end else begin
      resetOutN_reg <= (state_next == ST_RUN);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regulatorOn_reg <= REG_ON_RST;
    end else begin
      regulatorOn_reg <= enableIn;
    end
  end

  assign wakeupOut = wakeupOut_reg;
  assign resetOutN = resetOutN_reg;
  assign regulatorOn = regulatorOn_reg;

endmodule : wws_supervisor

/* tb/test_wws_supervisor.sv */
// Self-checking testbench for the wake-up watchdog reset supervisor
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module test_wws_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import wws_pkg::*;
  // Long enough that the host keeps its least service gap inside the high half
  localparam int P = 1600;
  localparam int RD = P / 8;
  localparam int SD = P / 2;
  logic ref_clk = 1'h0;
  logic sysRst = 1'h1;
  logic svcIn;
  logic inReg = 1'h0;
  logic outLow = 1'h0;
  logic supLow = 1'h0;
  logic enIn = 1'h0;
  logic [1:0] hostMode = 2'h0;
  logic wakeupOut;
  logic resetOutN;
  logic regulatorOn;
  int errors = 0;
  int n_checks = 0;

  always #4 ref_clk = ~ref_clk;

  wws_supervisor #(.PERIOD_CYC(P)) u_wws_supervisor (
    .ref_clk(ref_clk), .sys_rst(sysRst), .host_service_pulse_in(svcIn),
    .regulated_output_in_reg(inReg), .regulated_output_low(outLow), .supply_input_low(supLow),
    .enableIn(enIn), .wakeupOut(wakeupOut), .resetOutN(resetOutN), .regulatorOn(regulatorOn)
  );
  wws_host_model u_wws_host_model (.ref_clk(ref_clk), .wakeupOut(wakeupOut), .mode(hostMode), .svcIn(svcIn));

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  // Cycles until reset (r=1) or wake-up (r=0) reaches level v
  task automatic waitSig(input logic r, input logic v, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (((r ? resetOutN : wakeupOut) !== v) && n < 2000);
  endtask : waitSig

  task automatic t_powerup();
    int n;
    @(posedge ref_clk);
    enIn <= 1'h1;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHK(resetOutN, 1'h0)
    `CHK(regulatorOn, 1'h1)
    @(posedge ref_clk);
    inReg <= 1'h1;
    waitSig(1'h1, 1'h1, n);
    `CHK(n >= RD && n <= RD + 4, 1'h1)
    waitSig(1'h0, 1'h1, n);
    `CHK(n >= SD - 1 && n <= SD + 3, 1'h1)
    $display("Test powerup done");
  endtask : t_powerup

  task automatic t_silent();
    int n;
    waitSig(1'h0, 1'h0, n);
    `CHK(n, SD)
    waitSig(1'h1, 1'h0, n);
    `CHK(n >= SD - 1 && n <= SD + 3, 1'h1)
    waitSig(1'h1, 1'h1, n);
    `CHK(n >= RD && n <= RD + 2, 1'h1)
    $display("Test silent host done");
  endtask : t_silent

  task automatic t_service();
    int n;
    int lows;
    for (int m = 1; m < 4; m++) begin
      @(posedge ref_clk);
      hostMode <= 2'(m);
      lows = 0;
      repeat (3 * P) begin
        @(posedge ref_clk);
        #1;
        if (resetOutN !== 1'h1) lows++;
      end
      `CHK(lows, 0)
      waitSig(1'h0, 1'h1, n);
      waitSig(1'h0, 1'h0, n);
      `CHK(n < SD, 1'h1)
    end
    $display("Test service done");
  endtask : t_service

  task automatic t_faults();
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      outLow <= (i == 0);
      supLow <= (i == 1);
      enIn <= (i != 2);
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK(resetOutN, 1'h0)
      `CHK(wakeupOut, 1'h0)
      `CHK(regulatorOn, 1'(i != 2))
      @(posedge ref_clk);
      outLow <= 1'h0;
      supLow <= 1'h0;
      enIn <= 1'h1;
      waitSig(1'h1, 1'h1, n);
      `CHK(n >= RD, 1'h1)
    end
    $display("Test faults done");
  endtask : t_faults

  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    sysRst <= 1'h0;
    t_powerup();
    t_silent();
    t_service();
    t_faults();
    end_sim();
  end
endmodule : test_wws_supervisor

/* tb/wws_host_model.sv */
// Host model answering wake-up rises with service pulses
module wws_host_model (
  input wire logic ref_clk,
  input wire logic wakeupOut,
  input wire logic [1:0] mode,
  output logic svcIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Least gap from wake-up rise to the service edge, in clock cycles
  localparam int GAP_CYC = wws_pkg::SERVICE_GAP_NS * wws_pkg::CLK_PER_US / 1000;
  // Mode 0 silent, 1 prompt, 2 double pulse, 3 slow
  initial svcIn = 1'h1;
  always @(posedge wakeupOut) begin
    if (mode != 2'h0) begin
      repeat ((mode == 2'h3) ? GAP_CYC + 100 : GAP_CYC) @(posedge ref_clk);
      svcIn <= 1'h0;
      repeat (3) @(posedge ref_clk);
      svcIn <= 1'h1;
      if (mode == 2'h2) begin
        repeat (3) @(posedge ref_clk);
        svcIn <= 1'h0;
        repeat (3) @(posedge ref_clk);
        svcIn <= 1'h1;
      end
    end
  end
endmodule : wws_host_model

/* tb/wws_supervisor_monitor.sv */
// Checker for the ports of the wake-up watchdog reset supervisor
module wws_supervisor_monitor
  import wws_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = 64
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic host_service_pulse_in,
  input wire logic regulated_output_in_reg,
  input wire logic regulated_output_low,
  input wire logic supply_input_low,
  input wire logic enableIn,
  input wire logic wakeupOut,
  input wire logic resetOutN,
  input wire logic regulatorOn
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Run-length counters
  // ----------------------------------------------------------------
  localparam int RD = PERIOD_CYC / 8;
  localparam int SD = PERIOD_CYC / 2;
  logic [15:0] goodCnt;
  logic [15:0] hiCnt;
  logic [15:0] wakeHi;
  wire logic powerGood = regulated_output_in_reg & ~regulated_output_low & ~supply_input_low & enableIn;

  function automatic logic [15:0] bump(input logic [15:0] c, input logic k);
    return k ? c + {15'h0000, c != 16'hFFFF} : 16'h0000;
  endfunction : bump

  always_ff @(posedge ref_clk) begin
    goodCnt <= sys_rst ? 16'h0000 : bump(goodCnt, powerGood);
  end
  always_ff @(posedge ref_clk) begin
    hiCnt <= sys_rst ? 16'h0000 : bump(hiCnt, resetOutN);
  end
  always_ff @(posedge ref_clk) begin
    wakeHi <= sys_rst ? 16'h0000 : bump(wakeHi, wakeupOut);
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_wake_low_rst; !resetOutN && $past(!resetOutN) |-> !wakeupOut; endproperty
  a_wake_low_rst: assert property (p_wake_low_rst) else $error("wake-up high during reset");
  property p_reg_follow; !$past(sys_rst) |-> regulatorOn == $past(enableIn); endproperty
  a_reg_follow: assert property (p_reg_follow) else $error("regulator does not follow enable");
  property p_supply; supply_input_low |=> !resetOutN; endproperty
  a_supply: assert property (p_supply) else $error("supply low without reset");
  property p_uv; regulated_output_low |=> !resetOutN; endproperty
  a_uv: assert property (p_uv) else $error("undervoltage without reset");
  property p_en_off; !enableIn |=> !resetOutN && !regulatorOn; endproperty
  a_en_off: assert property (p_en_off) else $error("shutdown not honoured");
  property p_pgood; !regulated_output_in_reg |=> !resetOutN; endproperty
  a_pgood: assert property (p_pgood) else $error("reset released out of regulation");
  property p_rst_delay; $rose(resetOutN) |-> goodCnt >= RD; endproperty
  a_rst_delay: assert property (p_rst_delay) else $error("reset delay too short");
  property p_start; $rose(wakeupOut) |-> hiCnt >= SD - 1; endproperty
  a_start: assert property (p_start) else $error("start delay too short");
  property p_duty; wakeupOut |-> wakeHi < SD; endproperty
  a_duty: assert property (p_duty) else $error("wake-up high too long");
  property p_service; $fell(host_service_pulse_in) && wakeupOut |-> ##[1:6] !wakeupOut; endproperty
  a_service: assert property (p_service) else $error("service edge did not end wake-up");

  c_release: cover property ($rose(resetOutN));
  c_service: cover property ($fell(host_service_pulse_in) && wakeupOut);
  c_wd_reset: cover property ($fell(resetOutN) && powerGood);
endmodule : wws_supervisor_monitor

bind wws_supervisor wws_supervisor_monitor #(.PERIOD_CYC(PERIOD_CYC)) u_wws_supervisor_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .host_service_pulse_in(host_service_pulse_in),
  .regulated_output_in_reg(regulated_output_in_reg), .regulated_output_low(regulated_output_low),
  .supply_input_low(supply_input_low), .enableIn(enableIn), .wakeupOut(wakeupOut),
  .resetOutN(resetOutN), .regulatorOn(regulatorOn)
);
